/* hw/ceau_pkg.sv */
// Purpose: Shared types and constants for the effective address unit
// Assumes: 8-bit data, 16-bit addresses
// Notes:   Mode codes are the unit's own request encoding
package ceau_pkg;

  // ---------------------------------------------------------------
  // Widths and constants
  // ---------------------------------------------------------------
  localparam int unsigned  ADDR_W      = 16;
  localparam int unsigned  DATA_W      = 8;
  localparam logic [7:0]   ZERO_PAGE   = 8'h00;
  localparam logic [2:0]   CYC_NONE    = 3'h0;
  localparam logic [2:0]   CYC_PAGE    = 3'h1;
  localparam logic [2:0]   CYC_BR_SAME = 3'h1;
  localparam logic [2:0]   CYC_BR_DIFF = 3'h2;
  localparam logic [7:0]   PTR_STEP    = 8'h01;
  localparam logic [15:0]  ADDR_STEP   = 16'h0001;

  // ---------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_ACCUM   = 4'h0,
    MODE_IMM     = 4'h1,
    MODE_ABS     = 4'h2,
    MODE_ZP      = 4'h3,
    MODE_ZP_X    = 4'h4,
    MODE_ZP_Y    = 4'h5,
    MODE_ABS_X   = 4'h6,
    MODE_ABS_Y   = 4'h7,
    MODE_IMPLIED = 4'h8,
    MODE_REL     = 4'h9,
    MODE_IND_X   = 4'ha,
    MODE_IND_Y   = 4'hb,
    MODE_ABS_IND = 4'hc
  } ceau_mode_e;

  // Request carrier
  typedef struct packed {
    ceau_mode_e        mode;
    logic [7:0]        byte2;
    logic [7:0]        byte3;
    logic [7:0]        idx_x;
    logic [7:0]        idx_y;
    logic [15:0]       pc_next;
    logic              br_taken;
  } ceau_req_s;

  // Result carrier
  typedef struct packed {
    logic [15:0]       addr;
    logic [7:0]        operand;
    logic              use_acc;
    logic              use_imm;
    logic              has_addr;
    logic              load_pc;
    logic [1:0]        oper_bytes;
    logic [2:0]        extra_cyc;
  } ceau_res_s;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD_LO = 3'b001,
    ST_WT_LO = 3'b010,
    ST_RD_HI = 3'b011,
    ST_WT_HI = 3'b100,
    ST_DONE  = 3'b101
  } ceau_state_e;

endpackage : ceau_pkg

/* hw/ceau_unit.sv */
// Purpose: Effective address generation and extra-cycle count per addressing mode
// Assumes: One 40 MHz clock; memory answers reads with a one-cycle rd_ack_i pulse
// Notes:   Indirect modes read two pointer bytes from memory before answering
//          Ready stays low for the first cycle after reset
`timescale 1ns/1ps

// Behaviour
// - Accumulator mode: one byte, acts on accumulator
// - Immediate mode: operand is second byte
// - Absolute: byte2 low, byte3 high address
// - Zero page: high address byte forced zero
// - Indexed zero page wraps within page zero
// - Indexed absolute adds X or Y to base
// - Implied mode: no address bytes follow
// - Relative: signed offset added to next PC
// - (ind,X) pointer wraps, reads two zero-page bytes
// - (ind),Y low plus Y, carry into high
// - Absolute indirect loads full PC from pointer
// - Page crossing by indexing adds one cycle
// - Taken branch same page adds one cycle
// - Taken branch other page adds two cycles
module ceau_unit
  import ceau_pkg::*;
#(
  parameter int unsigned ADDR_BITS = ADDR_W,
  parameter int unsigned DATA_BITS = DATA_W
)
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        req_valid_i,
  input  wire ceau_req_s   req_i,
  output logic             req_ready_o,
  output logic             mem_rd_o,
  output logic [15:0]      mem_addr_o,
  input  wire logic        rd_ack_i,
  input  wire logic [7:0]  rd_data_i,
  output logic             res_valid_o,
  output ceau_res_s        res_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ceau_state_e      state_ff,     nxt_state;
  ceau_req_s        req_ff,       nxt_req;
  logic [7:0]       lo_ff,        nxt_lo;
  logic             rd_ff,        nxt_rd;
  logic [15:0]      maddr_ff,     nxt_maddr;
  logic             rv_ff,        nxt_rv;
  ceau_res_s        res_ff,       nxt_res;
  logic             rdy_ff,       nxt_rdy;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // The datapath is cut for 16-bit addresses and 8-bit bytes only
  if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W)
  begin : g_width_check
    $error("ceau_unit supports only 16-bit addresses and 8-bit data");
  end

  // ---------------------------------------------------------------
  // Direct address arithmetic
  // ---------------------------------------------------------------
  logic [15:0] base_abs;
  logic [7:0]  idx_sel;
  logic [16:0] abs_sum;
  logic [15:0] rel_off;
  logic [15:0] rel_tgt;
  logic [8:0]  iy_lo;
  logic [7:0]  ptr_a;
  logic [7:0]  ptr_b;
  ceau_res_s   dres;
  logic        indirect;

  always_comb
  begin
    base_abs = {req_i.byte3, req_i.byte2};
    idx_sel  = (req_i.mode == MODE_ABS_Y || req_i.mode == MODE_ZP_Y) ? req_i.idx_y : req_i.idx_x;
    abs_sum  = {1'b0, base_abs} + {9'h000, idx_sel};
    rel_off  = {{8{req_i.byte2[7]}}, req_i.byte2};
    rel_tgt  = req_i.pc_next + rel_off;
    indirect = (req_i.mode == MODE_IND_X) || (req_i.mode == MODE_IND_Y) || (req_i.mode == MODE_ABS_IND);
    dres            = '0;
    dres.oper_bytes = 2'h1;
    unique case (req_i.mode)
      MODE_ACCUM:
      begin
        dres.use_acc    = 1'b1;
        dres.oper_bytes = 2'h0;
      end
      MODE_IMM:
      begin
        dres.use_imm = 1'b1;
        dres.operand = req_i.byte2;
      end
      MODE_ABS:
      begin
        dres.has_addr   = 1'b1;
        dres.addr       = base_abs;
        dres.oper_bytes = 2'h2;
      end
      MODE_ZP:
      begin
        dres.has_addr = 1'b1;
        dres.addr     = {ZERO_PAGE, req_i.byte2};
      end
      MODE_ZP_X, MODE_ZP_Y:
      begin
        dres.has_addr = 1'b1;
        dres.addr     = {ZERO_PAGE, 8'(req_i.byte2 + idx_sel)};
      end
      MODE_ABS_X, MODE_ABS_Y:
      begin
        dres.has_addr   = 1'b1;
        dres.addr       = abs_sum[15:0];
        dres.oper_bytes = 2'h2;
        dres.extra_cyc  = (abs_sum[15:8] != req_i.byte3) ? CYC_PAGE : CYC_NONE;
      end
      MODE_IMPLIED:
      begin
        dres.oper_bytes = 2'h0;
      end
      MODE_REL:
      begin
        dres.addr = rel_tgt;
        // Extra cycles only when the branch is taken
        if (req_i.br_taken)
        begin
          dres.load_pc   = 1'b1;
          dres.extra_cyc = (rel_tgt[15:8] == req_i.pc_next[15:8]) ? CYC_BR_SAME
                                                                  : CYC_BR_DIFF;
        end
      end
      default:
      begin
        dres.oper_bytes = (req_i.mode == MODE_ABS_IND) ? 2'h2 : 2'h1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Pointer bytes for the indirect modes
  // ---------------------------------------------------------------
  always_comb
  begin
    ptr_a = 8'(req_ff.byte2 + req_ff.idx_x);
    // Only the X form indexes its pointer; the Y form reads it as given
    ptr_b = (req_ff.mode == MODE_IND_X) ? ptr_a : req_ff.byte2;
    iy_lo = {1'b0, lo_ff} + {1'b0, req_ff.idx_y};
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_req   = req_ff;
    nxt_lo    = lo_ff;
    nxt_rd    = 1'b0;
    nxt_maddr = maddr_ff;
    nxt_rv    = 1'b0;
    nxt_res   = res_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        // A request is taken only while ready shows high
        if (req_valid_i && rdy_ff)
        begin
          nxt_req = req_i;
          if (indirect)
            nxt_state = ST_RD_LO;
          else
          begin
            nxt_res = dres;
            nxt_rv  = 1'b1;
          end
        end
      end
      ST_RD_LO:
      begin
        nxt_rd = 1'b1;
        if (req_ff.mode == MODE_ABS_IND)
          nxt_maddr = {req_ff.byte3, req_ff.byte2};
        else
          nxt_maddr = {ZERO_PAGE, ptr_b};
        nxt_state = ST_WT_LO;
      end
      ST_WT_LO:
      begin
        // Strobe stays up until memory answers
        if (rd_ack_i)
        begin
          nxt_lo    = rd_data_i;
          nxt_state = ST_RD_HI;
        end
        else
          nxt_rd = 1'b1;
      end
      ST_RD_HI:
      begin
        // Strobe was low for one cycle, so memory sees a fresh request
        nxt_rd = 1'b1;
        // Pointer step is a full 16-bit increment for absolute indirect; the zero-page pointer wraps within page zero
        if (req_ff.mode == MODE_ABS_IND)
          nxt_maddr = {req_ff.byte3, req_ff.byte2} + ADDR_STEP;
        else
          nxt_maddr = {ZERO_PAGE, 8'(ptr_b + PTR_STEP)};
        nxt_state = ST_WT_HI;
      end
      ST_WT_HI:
      begin
        if (rd_ack_i)
        begin
          nxt_res            = '0;
          nxt_res.has_addr   = 1'b1;
          nxt_res.oper_bytes = (req_ff.mode == MODE_ABS_IND) ? 2'h2 : 2'h1;
          unique case (req_ff.mode)
            // Low byte plus Y carries into the high pointer byte
            MODE_IND_Y:
            begin
              nxt_res.addr      = {8'(rd_data_i + {7'h00, iy_lo[8]}), iy_lo[7:0]};
              nxt_res.extra_cyc = iy_lo[8] ? CYC_PAGE : CYC_NONE;
            end
            MODE_ABS_IND:
            begin
              nxt_res.addr    = {rd_data_i, lo_ff};
              nxt_res.load_pc = 1'b1;
            end
            default:
            begin
              nxt_res.addr = {rd_data_i, lo_ff};
            end
          endcase
          nxt_state = ST_DONE;
        end
        else
          nxt_rd = 1'b1;
      end
      ST_DONE:
      begin
        nxt_rv    = 1'b1;
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_ff <= ST_IDLE;
      req_ff   <= '0;
      lo_ff    <= 8'h00;
      rd_ff    <= 1'b0;
      maddr_ff <= 16'h0000;
      rv_ff    <= 1'b0;
      res_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      lo_ff    <= nxt_lo;
      rd_ff    <= nxt_rd;
      maddr_ff <= nxt_maddr;
      rv_ff    <= nxt_rv;
      res_ff   <= nxt_res;
    end
  end

  // ---------------------------------------------------------------
  // Ready flop: high when the next state is idle
  // ---------------------------------------------------------------
  // An indirect request leaves idle at once, so ready drops on the taking edge
  always_comb
  begin
    nxt_rdy = (nxt_state == ST_IDLE);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdy_ff <= 1'b0;
    else
      rdy_ff <= nxt_rdy;
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign req_ready_o = rdy_ff;
  assign mem_rd_o    = rd_ff;
  assign mem_addr_o  = maddr_ff;
  assign res_valid_o = rv_ff;
  assign res_o       = res_ff;

endmodule : ceau_unit

/* testbench/ceau_mem_model.sv */
// Purpose: Memory model answering pointer reads of the address unit
// Assumes: One read at a time; ack is a one-cycle pulse
// Notes:   Latency 0..3 cycles from address bits; data bus toggles when idle
`timescale 1ns/1ps
module ceau_mem_model
  import ceau_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output logic             rd_ack_o,
  output logic [7:0]       rd_data_o
);
  // ---------------------------------------------------------------
  // Read responder
  // ---------------------------------------------------------------
  logic [1:0] cnt;
  logic       done;

  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      cnt <= 2'h0; done <= 1'b0; rd_ack_o <= 1'b0; rd_data_o <= 8'h00;
    end
    else
    begin
      rd_ack_o  <= 1'b0;
      rd_data_o <= ~rd_data_o;
      if (!mem_rd_i)
      begin
        done <= 1'b0; cnt <= 2'h0;
      end
      else if (!done && cnt == mem_addr_i[1:0])
      begin
        rd_ack_o  <= 1'b1;
        rd_data_o <= mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3c;
        done      <= 1'b1;
      end
      else if (!done)
        cnt <= cnt + 2'h1;
    end
endmodule : ceau_mem_model

/* testbench/ceau_unit_assertions.sv */
// Purpose: Port-level checks of the effective address unit
// Assumes: Direct results one cycle after the request is taken
// Notes:   Bound to every ceau_unit instance
`timescale 1ns/1ps
module ceau_unit_chk
  import ceau_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        req_valid_i,
  input wire ceau_req_s   req_i,
  input wire logic        req_ready_o,
  input wire logic        mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        res_valid_o,
  input wire ceau_res_s   res_o
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic       tk;
  ceau_mode_e m;
  assign tk = req_valid_i && req_ready_o;
  assign m  = req_i.mode;

  acc_mode_a: assert property (tk && m == MODE_ACCUM |=> res_valid_o && res_o.use_acc && res_o.oper_bytes == 2'h0)
    else $error("accumulator result wrong");
  imm_oper_a: assert property (tk && m == MODE_IMM |=> res_o.use_imm && res_o.operand == $past(req_i.byte2))
    else $error("immediate operand wrong");
  abs_addr_a: assert property (tk && m == MODE_ABS |=> res_o.addr == {$past(req_i.byte3), $past(req_i.byte2)})
    else $error("absolute address wrong");
  zp_high_a: assert property (tk && m == MODE_ZP |=> res_o.addr == {8'h00, $past(req_i.byte2)})
    else $error("zero page address wrong");
  zp_wrap_a: assert property (tk && m == MODE_ZP_X |=> res_o.addr[15:8] == 8'h00 &&
    res_o.addr[7:0] == $past(req_i.byte2) + $past(req_i.idx_x)) else $error("indexed zero page wrong");
  absx_sum_a: assert property (tk && m == MODE_ABS_X |=>
    res_o.addr == {$past(req_i.byte3), $past(req_i.byte2)} + $past(req_i.idx_x)) else $error("abs x wrong");
  impl_bytes_a: assert property (tk && m == MODE_IMPLIED |=> res_valid_o && res_o.oper_bytes == 2'h0)
    else $error("implied result wrong");
  rel_target_a: assert property (tk && m == MODE_REL |=>
    res_o.addr == $past(req_i.pc_next) + {{8{$past(req_i.byte2[7])}}, $past(req_i.byte2)}) else $error("branch target");
  br_cycles_a: assert property (tk && m == MODE_REL |=> res_o.extra_cyc == (!$past(req_i.br_taken) ? CYC_NONE :
    (res_o.addr[15:8] == $past(req_i.pc_next[15:8]) ? CYC_BR_SAME : CYC_BR_DIFF))) else $error("branch cycles");
  page_cyc_a: assert property (tk && m == MODE_ABS_Y |=>
    res_o.extra_cyc == ((res_o.addr[15:8] != $past(req_i.byte3)) ? CYC_PAGE : CYC_NONE)) else $error("page cycle");
  indx_ptr_a: assert property (tk && m == MODE_IND_X |-> ##2 mem_rd_o && mem_addr_o[15:8] == 8'h00 &&
    mem_addr_o[7:0] == $past(req_i.byte2, 2) + $past(req_i.idx_x, 2)) else $error("ind x pointer");
  indy_ptr_a: assert property (tk && m == MODE_IND_Y |-> ##2 mem_rd_o &&
    mem_addr_o == {8'h00, $past(req_i.byte2, 2)}) else $error("ind y pointer");
  absind_ptr_a: assert property (tk && m == MODE_ABS_IND |-> ##2 mem_rd_o &&
    mem_addr_o == {$past(req_i.byte3, 2), $past(req_i.byte2, 2)}) else $error("indirect pointer");
  ind_done_a: assert property (tk && m inside {MODE_IND_X, MODE_IND_Y, MODE_ABS_IND} |-> ##[4:40] res_valid_o)
    else $error("indirect result late");
  cov_diff_c: cover property (res_valid_o && res_o.extra_cyc == CYC_BR_DIFF);
  cov_page_c: cover property (tk && m == MODE_ABS_X ##1 res_o.extra_cyc == CYC_PAGE);
  cov_indy_c: cover property (tk && m == MODE_IND_Y);
endmodule : ceau_unit_chk

bind ceau_unit ceau_unit_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .res_valid_o(res_valid_o), .res_o(res_o));

/* testbench/ceau_unit_tb.sv */
// Purpose: Self-checking bench of the effective address unit
// Assumes: Memory byte at a is a[7:0]^a[15:8]^3c
// Notes:   Corner requests first, then one per mode, then random
`timescale 1ns/1ps
module ceau_unit_tb
  import ceau_pkg::*;
  ;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic        clk_i, sys_rst_i, req_valid_i, req_ready_o, mem_rd_o, rd_ack_i, res_valid_o;
  logic [15:0] mem_addr_o;
  logic [7:0]  rd_data_i;
  ceau_req_s   req_i;
  ceau_res_s   res_o;
  int          bad_count, comparisons, cycles;
  ceau_req_s   r;

  ceau_unit u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .rd_ack_i(rd_ack_i),
    .rd_data_i(rd_data_i), .res_valid_o(res_valid_o), .res_o(res_o));
  ceau_mem_model u_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
    .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i));

  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mb

  function automatic logic [15:0] exp_addr(input ceau_req_s q);
    logic [7:0] p;
    p = q.byte2 + q.idx_x;
    case (q.mode)
      MODE_ABS:     return {q.byte3, q.byte2};
      MODE_ZP:      return {8'h00, q.byte2};
      MODE_ZP_X:    return {8'h00, p};
      MODE_ZP_Y:    return {8'h00, q.byte2 + q.idx_y};
      MODE_ABS_X:   return {q.byte3, q.byte2} + q.idx_x;
      MODE_ABS_Y:   return {q.byte3, q.byte2} + q.idx_y;
      MODE_REL:     return q.pc_next + {{8{q.byte2[7]}}, q.byte2};
      MODE_IND_X:   return {mb({8'h00, p + 8'h01}), mb({8'h00, p})};
      MODE_IND_Y:   return {mb({8'h00, q.byte2 + 8'h01}), mb({8'h00, q.byte2})} + q.idx_y;
      MODE_ABS_IND: return {mb({q.byte3, q.byte2} + 16'h0001), mb({q.byte3, q.byte2})};
      default:      return 16'h0000;
    endcase
  endfunction : exp_addr

  function automatic logic [2:0] exp_cyc(input ceau_req_s q);
    logic [15:0] a;
    a = exp_addr(q);
    case (q.mode)
      MODE_ABS_X, MODE_ABS_Y: return (a[15:8] != q.byte3) ? 3'h1 : 3'h0;
      MODE_IND_Y:  return (a[15:8] != mb({8'h00, q.byte2 + 8'h01})) ? 3'h1 : 3'h0;
      MODE_REL:    return !q.br_taken ? 3'h0 : (a[15:8] == q.pc_next[15:8]) ? 3'h1 : 3'h2;
      default:     return 3'h0;
    endcase
  endfunction : exp_cyc

  function automatic ceau_req_s mk(input ceau_mode_e md, input logic [7:0] b2, b3, x, y,
                                   input logic [15:0] pc, input logic tkn);
    return '{md, b2, b3, x, y, pc, tkn};
  endfunction : mk

  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic run(input ceau_req_s q);
    int n;
    @(posedge clk_i);
    while (req_ready_o !== 1'b1) @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i       <= q;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    #1;
    while (res_valid_o !== 1'b1 && n < 60)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("res_valid", 16'h1, 16'(res_valid_o));
    if (!(q.mode inside {MODE_ACCUM, MODE_IMM, MODE_IMPLIED})) chk("addr", exp_addr(q), res_o.addr);
    chk("extra_cyc", 16'(exp_cyc(q)), 16'(res_o.extra_cyc));
    chk("oper_bytes", (q.mode inside {MODE_ACCUM, MODE_IMPLIED}) ? 16'h0 :
      (q.mode inside {MODE_ABS, MODE_ABS_X, MODE_ABS_Y, MODE_ABS_IND}) ? 16'h2 : 16'h1, 16'(res_o.oper_bytes));
    chk("use_acc", 16'(q.mode == MODE_ACCUM), 16'(res_o.use_acc));
    if (q.mode == MODE_IMM) chk("operand", 16'(q.byte2), 16'(res_o.operand));
    chk("load_pc", 16'(q.mode == MODE_ABS_IND || (q.mode == MODE_REL && q.br_taken)), 16'(res_o.load_pc));
    chk("use_imm", 16'(q.mode == MODE_IMM), 16'(res_o.use_imm));
    chk("has_addr", 16'(!(q.mode inside {MODE_ACCUM, MODE_IMM, MODE_IMPLIED, MODE_REL})),
      16'(res_o.has_addr));
  endtask : run

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1; req_valid_i = 1'b0; req_i = '0;
    bad_count = 0; comparisons = 0; cycles = 0;
    void'($urandom(86680));
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    run(mk(MODE_ABS_X, 8'hff, 8'h12, 8'h01, 8'h00, 16'h0000, 1'b0));
    run(mk(MODE_ZP_X, 8'hf0, 8'h00, 8'h20, 8'h00, 16'h0000, 1'b0));
    run(mk(MODE_ZP_Y, 8'h80, 8'h00, 8'h00, 8'h90, 16'h0000, 1'b0));
    run(mk(MODE_REL, 8'h80, 8'h00, 8'h00, 8'h00, 16'h1005, 1'b1));
    run(mk(MODE_REL, 8'h10, 8'h00, 8'h00, 8'h00, 16'h1005, 1'b1));
    run(mk(MODE_REL, 8'h7f, 8'h00, 8'h00, 8'h00, 16'h10f0, 1'b0));
    run(mk(MODE_IND_X, 8'hfe, 8'h00, 8'h01, 8'h00, 16'h0000, 1'b0));
    run(mk(MODE_IND_Y, 8'hff, 8'h00, 8'h00, 8'hff, 16'h0000, 1'b0));
    run(mk(MODE_ABS_IND, 8'hff, 8'h20, 8'h00, 8'h00, 16'h0000, 1'b0));
    for (int i = 0; i < 213; i++)
    begin
      r = mk(ceau_mode_e'(4'(i < 13 ? i : $urandom_range(12))), 8'($urandom), 8'($urandom), 8'($urandom),
             8'($urandom), 16'($urandom), 1'($urandom));
      run(r);
    end
    conclude();
  end
endmodule : ceau_unit_tb
